// ==== mic_pkg.sv ====
// Constants, field layout and carrier types of the interrupt controller
// Summary of operation
// - Seven hardware event sources are latched
// - Hardware vectors only while global enable set
// - Trap vectors to 0x001, clears global enable
// - Return op sets global enable again
// - Flags stay set until software writes 0
// - Flags read back only where enabled
// - Enabled pending flag vectors to 0x008
// - Enable op inside routine allows nesting
// - Timer0 wrap sets flag bit 0
// - Timer1 wrap sets flag bit 3
// - Watchdog expiry in irq mode sets bit 6
// - Masked input pin change sets change flag
// - External select removes pin zero from change
// - Selected edge on pin zero sets flag
// - Falling detector output sets low supply flag
// - Live detector level readable in power reg
// - Finished nonvolatile write sets done flag
// - Timer0 flag and enable at bit 0
// - Timer1 flag and enable at bit 3
// - Wake from low power, vector if enabled
`default_nettype none
package mic_pkg;
    // ========================================
    // Register map (byte addresses)
    localparam logic [7:0] ADR_FLAG   = 8'h00;
    localparam logic [7:0] ADR_ENABLE = 8'h04;
    localparam logic [7:0] ADR_CTRL   = 8'h08;
    localparam logic [7:0] ADR_PWR1   = 8'h0c;
    localparam logic [7:0] ADR_CORE   = 8'h10;
    // ========================================
    // Event bit positions
    localparam int NUM_EV  = 7;
    localparam int EV_T0   = 0;
    localparam int EV_PCHG = 1;
    localparam int EV_EXT  = 2;
    localparam int EV_T1   = 3;
    localparam int EV_LVD  = 4;
    localparam int EV_NVW  = 5;
    localparam int EV_WDT  = 6;
    // ========================================
    // Control register fields
    localparam int NUM_PINS  = 6;
    localparam int CTL_MASK  = 0;
    localparam int CTL_XSEL  = 6;
    localparam int CTL_EDGE  = 7;
    localparam int CTL_LOWV  = 8;
    localparam int CTL_WDIRQ = 9;
    localparam int CTL_W     = 10;
    localparam int PWR1_LIVE = 6;
    localparam int CORE_GLB  = 0;
    // ========================================
    // Reset values and vectors
    localparam logic [NUM_EV-1:0] FLAG_RST = 7'h00;
    localparam logic [NUM_EV-1:0] EN_RST   = 7'h00;
    localparam logic [CTL_W-1:0]  CTL_RST  = 10'h000;
    localparam int                PC_W     = 10;
    localparam logic [PC_W-1:0]   VEC_TRAP = 10'h001;
    localparam logic [PC_W-1:0]   VEC_HW   = 10'h008;
    localparam logic [PC_W-1:0]   VEC_NONE = 10'h000;
    // ========================================
    // Carriers
    typedef struct packed {
        logic boundary;
        logic trap_op;
        logic enable_all_op;
        logic disable_all_op;
        logic return_from_isr_op;
    } mic_core_op_s;
    typedef struct packed {
        logic            valid;
        logic [PC_W-1:0] addr;
    } mic_vector_s;
endpackage
`default_nettype wire

// ==== mic_ctrl.sv ====
// Interrupt controller: event latching, vectoring and Wishbone registers
`timescale 1ns/1ns
`default_nettype none
module mic_ctrl
    import mic_pkg::*;
(
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    input  wire logic                wb_we_i,
    input  wire logic [7:0]          wb_adr_i,
    input  wire logic [3:0]          wb_sel_i,
    input  wire logic [31:0]         wb_dat_i,
    output logic      [31:0]         wb_dat_o,
    output logic                     wb_ack_o,
    input  wire mic_core_op_s        core_op_i,
    input  wire logic                low_power_i,
    input  wire logic                timer0_wrap_i,
    input  wire logic                timer1_wrap_i,
    input  wire logic                wdt_expire_i,
    input  wire logic [NUM_PINS-1:0] port_b_pin_i,
    input  wire logic [NUM_PINS-1:0] port_b_is_input_i,
    input  wire logic                low_supply_level_i,
    input  wire logic                nv_write_done_i,
    output mic_vector_s              vector_o,
    output logic                     global_irq_enable_o,
    output logic                     wake_o
);
    // ========================================
    // Bus decode
    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        hit = (a == r);
    endfunction

    logic [NUM_EV-1:0]   event_flag_reg;
    logic [NUM_EV-1:0]   event_enable_reg;
    logic [CTL_W-1:0]    ctrl_reg;
    logic                global_irq_enable;
    logic [NUM_PINS-1:0] pin_q;
    logic                lvd_q;

    // Reads load on the taking edge; writes land on the ack edge
    wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire xfer_ok = wb_cyc_i & wb_stb_i & wb_ack_o;
    wire wr_lo   = xfer_ok & wb_we_i & wb_sel_i[0];
    wire wr_hi   = xfer_ok & wb_we_i & wb_sel_i[1];
    wire wr_flag = wr_lo & hit(wb_adr_i, ADR_FLAG);
    wire wr_en   = wr_lo & hit(wb_adr_i, ADR_ENABLE);
    wire wr_ctl0 = wr_lo & hit(wb_adr_i, ADR_CTRL);
    wire wr_ctl1 = wr_hi & hit(wb_adr_i, ADR_CTRL);

    // ========================================
    // Event detection
    wire [NUM_PINS-1:0] pin_change_mask = ctrl_reg[CTL_MASK +: NUM_PINS];
    wire ext_pin_irq_select  = ctrl_reg[CTL_XSEL];
    wire ext_edge_polarity   = ctrl_reg[CTL_EDGE];
    wire low_supply_detect_on = ctrl_reg[CTL_LOWV];
    wire wdt_irq_mode        = ctrl_reg[CTL_WDIRQ];

    wire [NUM_PINS-1:0] pin0_mask = NUM_PINS'(ext_pin_irq_select);
    wire [NUM_PINS-1:0] pchg_sel =
        pin_change_mask & port_b_is_input_i & ~pin0_mask;
    wire pchg_ev = |((port_b_pin_i ^ pin_q) & pchg_sel);
    wire rise0   = port_b_pin_i[0] & ~pin_q[0];
    wire fall0   = ~port_b_pin_i[0] & pin_q[0];
    wire ext_ev  = ext_pin_irq_select &
                   (ext_edge_polarity ? rise0 : fall0);
    wire lvd_ev  = low_supply_detect_on & lvd_q &
                   ~low_supply_level_i;

    wire [NUM_EV-1:0] ev_set;
    assign ev_set[EV_T0]   = timer0_wrap_i;
    assign ev_set[EV_PCHG] = pchg_ev;
    assign ev_set[EV_EXT]  = ext_ev;
    assign ev_set[EV_T1]   = timer1_wrap_i;
    assign ev_set[EV_LVD]  = lvd_ev;
    assign ev_set[EV_NVW]  = nv_write_done_i;
    assign ev_set[EV_WDT]  = wdt_expire_i & wdt_irq_mode;

    // Writing 0 clears; a same-cycle event still wins
    wire [NUM_EV-1:0] flag_clr =
        wr_flag ? ~wb_dat_i[NUM_EV-1:0] : '0;
    wire [NUM_EV-1:0] next_flag =
        (event_flag_reg & ~flag_clr) | ev_set;

    // ========================================
    // Vectoring
    wire pending  = |(event_flag_reg & event_enable_reg);
    wire bnd      = core_op_i.boundary;
    wire take_sw  = bnd & core_op_i.trap_op;
    wire take_hw  = bnd & ~core_op_i.trap_op &
                    global_irq_enable & pending;
    wire set_glb  = bnd & (core_op_i.enable_all_op |
                           core_op_i.return_from_isr_op);
    wire clr_glb  = bnd & core_op_i.disable_all_op;
    // Vector entry outranks an op that would set the enable again
    wire next_glb = (take_sw | take_hw) ? 1'b0 :
                    set_glb ? 1'b1 :
                    clr_glb ? 1'b0 : global_irq_enable;
    wire [PC_W-1:0] next_addr = take_sw ? VEC_TRAP :
                                take_hw ? VEC_HW : VEC_NONE;

    // ========================================
    // Read mux
    wire [NUM_EV-1:0] flag_view = event_flag_reg & event_enable_reg;
    wire [31:0] rd_data =
        hit(wb_adr_i, ADR_FLAG)   ? 32'(flag_view) :
        hit(wb_adr_i, ADR_ENABLE) ? 32'(event_enable_reg) :
        hit(wb_adr_i, ADR_CTRL)   ? 32'(ctrl_reg) :
        hit(wb_adr_i, ADR_PWR1)   ?
            32'(low_supply_level_i) << PWR1_LIVE :
        hit(wb_adr_i, ADR_CORE)   ?
            32'(global_irq_enable) << CORE_GLB : 32'h0000_0000;

    wire [CTL_W-1:0] next_ctrl = {
        wr_ctl1 ? wb_dat_i[CTL_W-1:8] : ctrl_reg[CTL_W-1:8],
        wr_ctl0 ? wb_dat_i[7:0]       : ctrl_reg[7:0]};

    // ========================================
    // Registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            event_flag_reg   <= FLAG_RST;
            event_enable_reg <= EN_RST;
            ctrl_reg         <= CTL_RST;
            global_irq_enable <= 1'b0;
            wb_ack_o         <= 1'b0;
            wb_dat_o         <= 32'h0000_0000;
            vector_o         <= '0;
            wake_o           <= 1'b0;
        end
        else
        begin
            event_flag_reg   <= next_flag;
            event_enable_reg <= wr_en ? wb_dat_i[NUM_EV-1:0]
                                      : event_enable_reg;
            ctrl_reg         <= next_ctrl;
            global_irq_enable <= next_glb;
            wb_ack_o         <= bus_req;
            wb_dat_o         <= bus_req ? rd_data : wb_dat_o;
            vector_o         <= '{valid: take_sw | take_hw,
                                  addr:  next_addr};
            // Core sleeps on; vector choice waits for its next boundary
            wake_o           <= low_power_i & pending;
        end
    end

    // History for edges; pins see no edge on first sample after reset, supply history resets high so a low level reads as a fall
    always_ff @(posedge clk_i)
    begin
        pin_q <= port_b_pin_i;
        lvd_q <= rst_i ? 1'b1 : low_supply_level_i;
    end

    assign global_irq_enable_o = global_irq_enable;

    // ========================================
    // Assertions
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    AST_TRAP_VEC: assert property (
        take_sw |=> vector_o.valid && vector_o.addr == VEC_TRAP
                    && !global_irq_enable)
        else $error("trap did not vector to 0x001");
    AST_HW_VEC: assert property (
        bnd && !core_op_i.trap_op && global_irq_enable && pending
        |=> vector_o.valid && vector_o.addr == VEC_HW
            && !global_irq_enable)
        else $error("enabled pending flag not vectored");
    AST_NO_HW_WHEN_OFF: assert property (
        !global_irq_enable && !(bnd && core_op_i.trap_op)
        |=> !vector_o.valid)
        else $error("vector while global enable clear");
    AST_RET_SETS: assert property (
        bnd && core_op_i.return_from_isr_op && !core_op_i.trap_op
        && !(global_irq_enable && pending) |=> global_irq_enable)
        else $error("return op left global enable clear");
    AST_FLAG_HOLD: assert property (
        $past(event_flag_reg[EV_T0]) && !$past(wr_flag)
        |-> event_flag_reg[EV_T0])
        else $error("flag dropped without software write");
    AST_T1_SET: assert property (
        timer1_wrap_i |=> event_flag_reg[EV_T1])
        else $error("timer1 wrap not latched");
    AST_EIS_MASK: assert property (
        ext_pin_irq_select && !event_flag_reg[EV_PCHG]
        && port_b_pin_i[NUM_PINS-1:1] == pin_q[NUM_PINS-1:1]
        |=> !event_flag_reg[EV_PCHG])
        else $error("pin zero change seen under external select");
    AST_READ_MASK: assert property (
        bus_req && !wb_we_i && hit(wb_adr_i, ADR_FLAG)
        && !event_enable_reg[EV_WDT] |=> !wb_dat_o[EV_WDT])
        else $error("disabled flag visible on read");
    AST_ONE_VEC: assert property (
        vector_o.valid |=> !vector_o.valid || $past(bnd))
        else $error("vector without boundary");
    AST_ACK: assert property (
        bus_req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus ack not one cycle");

    // ========================================
    // Vectoring and wake checks
    // Vector entry outranks an op that would set the enable, so antecedents leave it out
    AST_NEST: assert property (
        bnd && core_op_i.enable_all_op && !core_op_i.trap_op
        && !(global_irq_enable && pending) |=> global_irq_enable)
        else $error("enable op left global enable clear");
    AST_DIS_CLR: assert property (
        bnd && core_op_i.disable_all_op && !core_op_i.enable_all_op
        && !core_op_i.return_from_isr_op |=> !global_irq_enable)
        else $error("disable op left global enable set");
    AST_NO_PENDING: assert property (
        bnd && global_irq_enable && !pending && !core_op_i.trap_op
        |=> !vector_o.valid)
        else $error("vector with no enabled flag pending");
    AST_VEC_IDLE: assert property (
        !vector_o.valid |-> vector_o.addr == VEC_NONE)
        else $error("vector address without valid");
    AST_WAKE: assert property (
        low_power_i && |(event_flag_reg & event_enable_reg) |=> wake_o)
        else $error("enabled flag did not wake core");
    AST_WAKE_IDLE: assert property (
        !low_power_i |=> !wake_o)
        else $error("wake raised outside low power");

    // ========================================
    // Event latching checks
    AST_T0_SET: assert property (
        timer0_wrap_i |=> event_flag_reg[EV_T0])
        else $error("timer0 wrap not latched");
    AST_WDT_SET: assert property (
        wdt_expire_i && wdt_irq_mode |=> event_flag_reg[EV_WDT])
        else $error("watchdog expiry not latched");
    AST_WDT_RST_MODE: assert property (
        wdt_expire_i && !wdt_irq_mode && !event_flag_reg[EV_WDT]
        |=> !event_flag_reg[EV_WDT])
        else $error("watchdog flag set in reset mode");
    AST_NVW_SET: assert property (
        nv_write_done_i |=> event_flag_reg[EV_NVW])
        else $error("write done not latched");
    // Upper pins only, so the select on pin zero cannot hide them
    AST_PCHG_SET: assert property (
        |(((port_b_pin_i ^ pin_q) & pin_change_mask
           & port_b_is_input_i) >> 1) |=> event_flag_reg[EV_PCHG])
        else $error("masked input change not latched");
    AST_PCHG_IGNORE: assert property (
        !(|((port_b_pin_i ^ pin_q) & pin_change_mask & port_b_is_input_i))
        && !event_flag_reg[EV_PCHG] |=> !event_flag_reg[EV_PCHG])
        else $error("change flag set without a watched change");
    AST_EXT_RISE: assert property (
        ext_pin_irq_select && ext_edge_polarity
        && port_b_pin_i[0] && !pin_q[0] |=> event_flag_reg[EV_EXT])
        else $error("rising edge on pin zero not latched");
    AST_EXT_FALL: assert property (
        ext_pin_irq_select && !ext_edge_polarity
        && !port_b_pin_i[0] && pin_q[0] |=> event_flag_reg[EV_EXT])
        else $error("falling edge on pin zero not latched");
    AST_EXT_OFF: assert property (
        !ext_pin_irq_select && !event_flag_reg[EV_EXT]
        |=> !event_flag_reg[EV_EXT])
        else $error("external flag set without select");
    AST_LVD_SET: assert property (
        low_supply_detect_on && $fell(low_supply_level_i)
        |=> event_flag_reg[EV_LVD])
        else $error("supply drop not latched");
    AST_LVD_OFF: assert property (
        !low_supply_detect_on && !event_flag_reg[EV_LVD]
        |=> !event_flag_reg[EV_LVD])
        else $error("supply flag set with detector off");
    AST_WR_CLEAR: assert property (
        wr_flag && !wb_dat_i[EV_T1] && !timer1_wrap_i
        |=> !event_flag_reg[EV_T1])
        else $error("software zero did not clear flag");

    // ========================================
    // Register store checks
    AST_LVD_LIVE: assert property (
        bus_req && !wb_we_i && hit(wb_adr_i, ADR_PWR1)
        |=> wb_dat_o[PWR1_LIVE] == $past(low_supply_level_i))
        else $error("live detector level not on read");
    AST_EN_STORE: assert property (
        wr_en |=> event_enable_reg == $past(wb_dat_i[NUM_EV-1:0]))
        else $error("enable write not stored");
    AST_CTRL_STORE: assert property (
        wr_ctl1 |=> ctrl_reg[CTL_WDIRQ] == $past(wb_dat_i[CTL_WDIRQ]))
        else $error("control write not stored");
    // Read data must stand between transfers
    AST_DAT_HOLD: assert property (
        !bus_req |=> $stable(wb_dat_o))
        else $error("read data moved without a request");

    // ========================================
    // Cover points
    COV_TRAP: cover property (take_sw);
    COV_HW:   cover property (take_hw ##[1:20] set_glb);
    COV_NEST: cover property (take_hw ##1 set_glb ##[1:20] take_hw);
    COV_WAKE: cover property (wake_o);
    COV_EXT:  cover property (ext_ev && !ext_edge_polarity);
endmodule
`default_nettype wire

// ==== mic_core_model.sv ====
// Core-side model: issues boundary ops and records the vector taken
`timescale 1ns/1ns
`default_nettype none
module mic_core_model
    import mic_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        go_i,
    input  wire logic [2:0]  cmd_i,
    input  wire mic_vector_s vector_i,
    output mic_core_op_s     core_op_o,
    output logic [PC_W-1:0]  vec_seen_o
);
    logic last_en;
    // A return op right after an enable op is not passed to the controller
    wire  ret_ok = !(last_en && cmd_i == 3'h4);
    assign core_op_o = {go_i, go_i && cmd_i == 3'h1, go_i && cmd_i == 3'h2,
                        go_i && cmd_i == 3'h3,
                        go_i && ret_ok && cmd_i == 3'h4};
    always_ff @(posedge clk_i)
    begin
        if (rst_i || go_i)
            vec_seen_o <= VEC_NONE;
        else if (vector_i.valid)
            vec_seen_o <= vector_i.addr;
        if (rst_i)
            last_en <= 1'b0;
        else if (go_i)
            last_en <= core_op_o.enable_all_op;
    end
endmodule
`default_nettype wire

// ==== testbench.sv ====
// Self-checking bench for the interrupt controller
`timescale 1ns/1ns
`default_nettype none
module testbench import mic_pkg::*;;
    logic         clk_i = 1'b0;
    logic         rst_i = 1'b1;
    logic         cyc = 1'b0, stb = 1'b0, we = 1'b0, go = 1'b0;
    logic         lvl = 1'b1, lowp = 1'b0, wake, glb_en, ack;
    logic [2:0]   cmd = 3'h0;
    logic [3:0]   evp = 4'h0;
    logic [5:0]   pin = 6'h00, isin = 6'h3f;
    logic [7:0]   adr = 8'h00;
    logic [31:0]  wdat = 32'h0, rdat, dat_o;
    logic [9:0]   vec_seen;
    mic_core_op_s op;
    mic_vector_s  vec;
    int           n_fail = 0, compares = 0;
    always #2 clk_i = ~clk_i;
    mic_ctrl uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .core_op_i(op), .low_power_i(lowp),
        .timer0_wrap_i(evp[0]), .timer1_wrap_i(evp[1]), .wdt_expire_i(evp[2]),
        .port_b_pin_i(pin), .port_b_is_input_i(isin),
        .low_supply_level_i(lvl), .nv_write_done_i(evp[3]), .vector_o(vec),
        .global_irq_enable_o(glb_en), .wake_o(wake));
    mic_core_model core (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .cmd_i(cmd),
        .vector_i(vec), .core_op_o(op), .vec_seen_o(vec_seen));
    // ========================================
    // Access tasks
    task test_done;
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do
            @(posedge clk_i);
        while (ack !== 1'b1);
        rdat = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rdat, e);
    endtask
    // Boundary op, then the vector seen by the core and the enable
    task step(input logic [2:0] c, input logic [9:0] v, input logic g);
        @(posedge clk_i);
        go <= 1'b1;
        cmd <= c;
        @(posedge clk_i);
        go <= 1'b0;
        @(posedge clk_i);
        #1;
        chk(32'(vec_seen), 32'(v));
        chk(32'(glb_en), 32'(g));
    endtask
    task pulse(input logic [3:0] v);
        @(posedge clk_i);
        evp <= v;
        @(posedge clk_i);
        evp <= 4'h0;
        repeat (2) @(posedge clk_i);
    endtask
    task setpin(input logic [5:0] p);
        @(posedge clk_i);
        pin <= p;
        repeat (2) @(posedge clk_i);
    endtask
    // ========================================
    // Tests
    initial
    begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(ADR_FLAG, 32'h0);
        rd(ADR_ENABLE, 32'h0);
        rd(ADR_CORE, 32'h0);
        rd(8'h14, 32'h0);
        $display("test reset done");
        bus(1'b1, ADR_ENABLE, 32'h7f);
        pulse(4'h4);
        pulse(4'hb);
        rd(ADR_FLAG, 32'h29);
        bus(1'b1, ADR_CTRL, 32'h200);
        pulse(4'h4);
        rd(ADR_FLAG, 32'h69);
        bus(1'b1, ADR_ENABLE, 32'h09);
        rd(ADR_FLAG, 32'h09);
        bus(1'b1, ADR_ENABLE, 32'h7f);
        bus(1'b1, ADR_FLAG, 32'h7e);
        rd(ADR_FLAG, 32'h68);
        $display("test flags done");
        step(3'h0, VEC_NONE, 1'b0);
        step(3'h2, VEC_NONE, 1'b1);
        rd(ADR_CORE, 32'h1);
        step(3'h0, VEC_HW, 1'b0);
        step(3'h2, VEC_NONE, 1'b1);
        step(3'h0, VEC_HW, 1'b0);
        step(3'h1, VEC_TRAP, 1'b0);
        step(3'h4, VEC_NONE, 1'b1);
        step(3'h1, VEC_TRAP, 1'b0);
        bus(1'b1, ADR_FLAG, 32'h0);
        rd(ADR_FLAG, 32'h0);
        step(3'h4, VEC_NONE, 1'b1);
        step(3'h0, VEC_NONE, 1'b1);
        step(3'h3, VEC_NONE, 1'b0);
        $display("test vectors done");
        bus(1'b1, ADR_CTRL, 32'h03f);
        setpin(6'h08);
        rd(ADR_FLAG, 32'h02);
        bus(1'b1, ADR_FLAG, 32'h0);
        isin <= 6'h1f;
        setpin(6'h28);
        rd(ADR_FLAG, 32'h0);
        bus(1'b1, ADR_CTRL, 32'h0ff);
        setpin(6'h29);
        rd(ADR_FLAG, 32'h04);
        bus(1'b1, ADR_FLAG, 32'h0);
        setpin(6'h28);
        rd(ADR_FLAG, 32'h0);
        bus(1'b1, ADR_CTRL, 32'h07f);
        setpin(6'h29);
        rd(ADR_FLAG, 32'h0);
        setpin(6'h28);
        rd(ADR_FLAG, 32'h04);
        bus(1'b1, ADR_FLAG, 32'h0);
        $display("test pins done");
        bus(1'b1, ADR_CTRL, 32'h100);
        rd(ADR_PWR1, 32'h40);
        lvl <= 1'b0;
        rd(ADR_FLAG, 32'h10);
        rd(ADR_PWR1, 32'h0);
        lowp <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk(32'(wake), 32'h1);
        step(3'h0, VEC_NONE, 1'b0);
        step(3'h2, VEC_NONE, 1'b1);
        step(3'h0, VEC_HW, 1'b0);
        $display("test supply and wake done");
        test_done();
    end
    // Whole run needs well under a thousand cycles
    initial
    begin
        #20000;
        n_fail++;
        test_done();
    end
endmodule
`default_nettype wire
